// File: msd_decoder.sv
// Top of the memory space decoder: routing of core accesses and its own SFRs.
`timescale 1ns/1ps
`default_nettype none
module msd_decoder (
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire msd_pkg::msd_req_t   req,
    input  wire logic [7:0]          ptr_val,
    input  wire logic [1:0]          bank_sel,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    input  wire logic [7:0]          sfr_addr,
    input  wire logic [7:0]          sfr_wdata,
    input  wire logic [7:0]          nv_trim,
    input  wire logic [7:0]          nv_cust0,
    input  wire logic [7:0]          nv_cust1,
    output msd_pkg::msd_route_t      route,
    output logic [4:0]               bank_addr,
    output logic                     sfr_hit,
    output logic [7:0]               sfr_rdata,
    output logic [1:0]               page,
    output logic [7:0]               opt_index,
    output logic [7:0]               oscillator_trim_option,
    output logic [7:0]               customer_option_zero,
    output logic [7:0]               customer_option_one,
    output logic                     options_loaded
);
    typedef struct packed {
        logic [7:0]          index;
        logic [1:0]          page;
        msd_pkg::msd_route_t route;
    } msd_top_t;

    msd_top_t            st_r;
    msd_top_t            st_nxt;
    logic [7:0]          opt_rdata;
    logic                opt_wr;
    msd_pkg::msd_route_t rt;

    // Only this block's own SFRs are answered here; every other SFR address
    // reads zero from this block so the core may OR all SFR read buses.
    function automatic logic own_sfr(input logic [7:0] a);
        own_sfr = (a == msd_pkg::SFR_EXT_PAGE) || (a == msd_pkg::SFR_OPT_INDEX)
               || (a == msd_pkg::SFR_OPT_DATA);
    endfunction

    assign opt_wr = sfr_wr && (sfr_addr == msd_pkg::SFR_OPT_DATA);

    always_comb begin
        st_nxt       = st_r;
        st_nxt.route = rt;
        if (sfr_wr && sfr_addr == msd_pkg::SFR_OPT_INDEX) begin
            st_nxt.index = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == msd_pkg::SFR_EXT_PAGE) begin
            st_nxt.page = sfr_wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.index <= msd_pkg::OPT_INDEX_RST;
            st_r.page  <= msd_pkg::EXT_PAGE_RST;
            st_r.route <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    msd_option_bank u_opt (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .nv_trim (nv_trim),
        .nv_cust0(nv_cust0),
        .nv_cust1(nv_cust1),
        .index   (st_r.index),
        .data_wr (opt_wr),
        .wdata   (sfr_wdata),
        .rdata   (opt_rdata),
        .loaded  (options_loaded),
        .trim    (oscillator_trim_option),
        .cust0   (customer_option_zero),
        .cust1   (customer_option_one)
    );

    always_comb begin
        sfr_hit   = sfr_rd && own_sfr(sfr_addr);
        sfr_rdata = 8'h00;
        if (sfr_rd) begin
            unique case (sfr_addr)
                msd_pkg::SFR_EXT_PAGE:  sfr_rdata = {6'h00, st_r.page};
                msd_pkg::SFR_OPT_INDEX: sfr_rdata = st_r.index;
                msd_pkg::SFR_OPT_DATA:  sfr_rdata = opt_rdata;
                default:                sfr_rdata = 8'h00;
            endcase
        end
    end

    // Routing is decoded here and registered with the rest of the state, so the
    // target shows one cycle after the request and stays glitch free.
    always_comb begin
        rt = '0;
        rt.target = msd_pkg::MSD_TGT_NONE;
        unique case (req.kind)
            msd_pkg::MSD_DIRECT: begin
                if (req.bit_op) begin
                    // Bit numbers below 80H map into bytes 20H-2FH.
                    if (req.addr[7] == 1'b0) begin
                        rt.target   = msd_pkg::MSD_TGT_RAM_LOW;
                        rt.ram_addr = {2'h0, msd_pkg::BIT_BYTE_BASE[7:4],
                                       req.addr[6:3]};
                        rt.bit_pos  = req.addr[2:0];
                        rt.bit_ok   = 1'b1;
                    end else begin
                        // Bit space above 7FH reaches SFRs ending in 0 or 8.
                        rt.target   = msd_pkg::MSD_TGT_SFR;
                        rt.ram_addr = {2'h0, req.addr[7:3], 3'h0};
                        rt.bit_pos  = req.addr[2:0];
                        rt.bit_ok   = 1'b1;
                    end
                end else if (req.addr[7:0] >= msd_pkg::SFR_BASE) begin
                    rt.target   = msd_pkg::MSD_TGT_SFR;
                    rt.ram_addr = {2'h0, req.addr[7:0]};
                end else begin
                    rt.target   = msd_pkg::MSD_TGT_RAM_LOW;
                    rt.ram_addr = {2'h0, req.addr[7:0]};
                end
            end
            msd_pkg::MSD_INDIRECT: begin
                rt.ram_addr = {2'h0, req.addr[7:0]};
                if (req.addr[7:0] >= msd_pkg::SFR_BASE) begin
                    rt.target = msd_pkg::MSD_TGT_RAM_HIGH;
                end else begin
                    rt.target = msd_pkg::MSD_TGT_RAM_LOW;
                end
            end
            msd_pkg::MSD_EXTERNAL: begin
                if (req.byte_ptr) begin
                    rt.ram_addr = {st_r.page, ptr_val};
                    rt.target   = msd_pkg::MSD_TGT_EXT_RAM;
                    rt.fault    = ({6'h00, st_r.page, ptr_val} > msd_pkg::EXT_RAM_TOP);
                end else if (req.addr <= msd_pkg::EXT_RAM_TOP) begin
                    rt.ram_addr = req.addr[9:0];
                    rt.target   = msd_pkg::MSD_TGT_EXT_RAM;
                end else begin
                    rt.fault    = 1'b1;
                end
            end
            default: ;
        endcase
    end

    assign route = st_r.route;

    // Working register Rn lives at bank * 8 + n within 00H-1FH.
    assign bank_addr = {bank_sel, req.addr[2:0]};
    assign page      = st_r.page;
    assign opt_index = st_r.index;
endmodule
`default_nettype wire

// File: msd_pkg.sv
// Package of constants and carrier types for the memory space decoder.
// Function
// - Option index pointer at FEH, option data port at FFH; pointer resets to zero.
// - Data port write stores to selected option register; read returns it.
// - Internal RAM 00H-FFH; low half direct and indirect, upper half indirect only.
// - Direct 80H-FFH goes to SFRs; indirect 80H-FFH goes to upper RAM.
// - External RAM 0000H-02FFH, reached only by external-RAM accesses.
// - Byte-pointer external address is page bits above the 8-bit pointer.
// - 00H-1FH holds four register banks chosen by two status-word bits.
// - Bytes 20H-2FH also give 128 bits numbered 00H-7FH for bit access.
// - Only SFRs ending in 0 or 8 are bit addressable; SFRs direct only.
// - Empty SFR addresses have no storage behind them.
// - External RAM page register at F7H, bits 1-0 page, bits 7-2 reserved.
// - Option set is trim at 83H and customer options at C1H and C2H.
// - Every reset loads option registers from the nonvolatile option area.
package msd_pkg;
    localparam logic [7:0]  SFR_EXT_PAGE   = 8'hf7;
    localparam logic [7:0]  SFR_OPT_INDEX  = 8'hfe;
    localparam logic [7:0]  SFR_OPT_DATA   = 8'hff;
    localparam logic [7:0]  OPT_IDX_TRIM   = 8'h83;
    localparam logic [7:0]  OPT_IDX_CUST0  = 8'hc1;
    localparam logic [7:0]  OPT_IDX_CUST1  = 8'hc2;
    localparam logic [7:0]  OPT_INDEX_RST  = 8'h00;
    localparam logic [1:0]  EXT_PAGE_RST   = 2'h0;
    localparam logic [7:0]  SFR_BASE       = 8'h80;
    localparam logic [7:0]  BANK_TOP       = 8'h1f;
    localparam logic [7:0]  BIT_BYTE_BASE  = 8'h20;
    localparam logic [15:0] EXT_RAM_TOP    = 16'h02ff;

    typedef enum logic [1:0] {
        MSD_NONE,
        MSD_DIRECT,
        MSD_INDIRECT,
        MSD_EXTERNAL
    } msd_kind_t;

    typedef enum logic [2:0] {
        MSD_TGT_NONE,
        MSD_TGT_RAM_LOW,
        MSD_TGT_RAM_HIGH,
        MSD_TGT_SFR,
        MSD_TGT_EXT_RAM
    } msd_target_t;

    typedef struct packed {
        msd_kind_t   kind;
        logic        byte_ptr;
        logic        bit_op;
        logic [15:0] addr;
    } msd_req_t;

    typedef struct packed {
        msd_target_t target;
        logic [9:0]  ram_addr;
        logic [2:0]  bit_pos;
        logic        bit_ok;
        logic        fault;
    } msd_route_t;

    typedef struct packed {
        logic [7:0] index;
        logic [7:0] trim;
        logic [7:0] cust0;
        logic [7:0] cust1;
        logic [1:0] page;
        logic       loaded;
    } msd_state_t;
endpackage

// File: msd_option_bank.sv
// Option register bank reached through the index pointer and data port.
`timescale 1ns/1ps
`default_nettype none
module msd_option_bank (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  nv_trim,
    input  wire logic [7:0]  nv_cust0,
    input  wire logic [7:0]  nv_cust1,
    input  wire logic [7:0]  index,
    input  wire logic        data_wr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    output logic             loaded,
    output logic      [7:0]  trim,
    output logic      [7:0]  cust0,
    output logic      [7:0]  cust1
);
    msd_pkg::msd_state_t st_r;
    msd_pkg::msd_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Load happens in the first cycle after reset release, since async
        // reset may only place constants in the flops.
        if (!st_r.loaded) begin
            st_nxt.trim   = nv_trim;
            st_nxt.cust0  = nv_cust0;
            st_nxt.cust1  = nv_cust1;
            st_nxt.loaded = 1'b1;
        end else if (data_wr) begin
            unique case (index)
                msd_pkg::OPT_IDX_TRIM:  st_nxt.trim  = wdata;
                msd_pkg::OPT_IDX_CUST0: st_nxt.cust0 = wdata;
                msd_pkg::OPT_IDX_CUST1: st_nxt.cust1 = wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        unique case (index)
            msd_pkg::OPT_IDX_TRIM:  rdata = st_r.trim;
            msd_pkg::OPT_IDX_CUST0: rdata = st_r.cust0;
            msd_pkg::OPT_IDX_CUST1: rdata = st_r.cust1;
            default:                rdata = 8'h00;
        endcase
    end

    assign loaded = st_r.loaded;
    assign trim   = st_r.trim;
    assign cust0  = st_r.cust0;
    assign cust1  = st_r.cust1;
endmodule
`default_nettype wire

// File: msd_decoder_assertions.sv
// Port-level assertions for the memory space decoder.
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_assertions (
    input wire logic                clk_sys,
    input wire logic                sys_rst,
    input wire msd_pkg::msd_req_t   req,
    input wire logic [7:0]          ptr_val,
    input wire logic [1:0]          bank_sel,
    input wire logic                sfr_wr,
    input wire logic                sfr_rd,
    input wire logic [7:0]          sfr_addr,
    input wire logic [7:0]          sfr_wdata,
    input wire logic [7:0]          nv_trim,
    input wire msd_pkg::msd_route_t route,
    input wire logic [4:0]          bank_addr,
    input wire logic [7:0]          sfr_rdata,
    input wire logic [1:0]          page,
    input wire logic [7:0]          opt_index,
    input wire logic [7:0]          oscillator_trim_option,
    input wire logic                options_loaded
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_rst_vals; $fell(sys_rst) |-> opt_index == 8'h00 && page == 2'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");
    property p_trim_wr; sfr_wr && sfr_addr == 8'hff && opt_index == 8'h83 && options_loaded
        |=> oscillator_trim_option == $past(sfr_wdata); endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
    property p_page_wr; sfr_wr && sfr_addr == 8'hf7
        |=> {6'h00, page} == ($past(sfr_wdata) & 8'h03); endproperty
    a_page_wr: assert property (p_page_wr) else $error("page write wrong");
    property p_unmapped; sfr_rd && !(sfr_addr inside {8'hf7, 8'hfe, 8'hff})
        |-> sfr_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("empty address read");
    property p_sfr_route; req.kind == msd_pkg::MSD_DIRECT && req.addr[7]
        |=> route.target == msd_pkg::MSD_TGT_SFR; endproperty
    a_sfr_route: assert property (p_sfr_route) else $error("direct high missed");
    property p_byte_ptr; req.kind == msd_pkg::MSD_EXTERNAL && req.byte_ptr
        |=> route.ram_addr == {$past(page), $past(ptr_val)}; endproperty
    a_byte_ptr: assert property (p_byte_ptr) else $error("paged address wrong");
    property p_bank; req.kind != msd_pkg::MSD_NONE
        |-> bank_addr == {bank_sel, req.addr[2:0]}; endproperty
    a_bank: assert property (p_bank) else $error("bank address wrong");
    // Two edges cover the load cycle and the cycle in which the flag is seen.
    property p_opt_load; $fell(sys_rst)
        |-> ##2 (options_loaded && oscillator_trim_option == $past(nv_trim, 2)); endproperty
    a_opt_load: assert property (p_opt_load) else $error("option load wrong");
endmodule
bind msd_decoder msd_decoder_assertions i_chk (.*);
`default_nettype wire

// File: msd_core_model.sv
// Core-side model issuing SFR and memory accesses.
`timescale 1ns/1ps
`default_nettype none
module msd_core_model (
    input  wire logic          clk_sys,
    output msd_pkg::msd_req_t  req,
    output logic [7:0]         ptr_val,
    output logic [1:0]         bank_sel,
    output logic               sfr_wr,
    output logic               sfr_rd,
    output logic [7:0]         sfr_addr,
    output logic [7:0]         sfr_wdata
);
    initial {req, ptr_val, bank_sel, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == msd_pkg::SFR_OPT_INDEX && !(d inside {8'h83, 8'hc1, 8'hc2})) return;
        @(posedge clk_sys);
        {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        // Released address and data show their inverse so a stale byte never looks valid.
        {sfr_wr, sfr_addr, sfr_wdata} <= {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        {sfr_rd, sfr_addr} <= {1'b1, a};
        @(posedge clk_sys);
        {sfr_rd, sfr_addr} <= {1'b0, ~a};
    endtask
    task automatic mem(input msd_pkg::msd_req_t r, input logic [7:0] p, input logic [1:0] b);
        @(posedge clk_sys);
        {req, ptr_val, bank_sel} <= {r, p, b};
        repeat (2) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// File: memory_space_decoder_tb_top.sv
// Self-checking bench for the memory space decoder.
`timescale 1ns/1ps
`default_nettype none
module memory_space_decoder_tb_top;
    logic                clk_sys = 1'b0;
    logic                sys_rst = 1'b1;
    logic [7:0]          nv_trim = 8'h00, nv_cust0 = 8'h00, nv_cust1 = 8'h00, d, a, p;
    int                  num_errors = 0, checked = 0, seed = 11639;
    msd_pkg::msd_req_t   req, r;
    msd_pkg::msd_route_t route;
    logic [7:0]          ptr_val, sfr_addr, sfr_wdata, sfr_rdata, opt_index;
    logic [7:0]          oscillator_trim_option, customer_option_zero, customer_option_one;
    logic [1:0]          bank_sel, page, pg, b;
    logic [4:0]          bank_addr;
    logic                sfr_wr, sfr_rd, sfr_hit, options_loaded;
    logic [12:0]         e;
    logic [7:0]          idx [3] = '{8'h83, 8'hc1, 8'hc2};
    msd_decoder i_dut (.*);
    msd_core_model i_core (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        checked++;
        if (s !== x) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Expected target and RAM address; the address is 000H for a refused request.
    function automatic logic [12:0] exp_route(msd_pkg::msd_req_t q, logic [1:0] g, logic [7:0] v);
        case (q.kind)
            msd_pkg::MSD_DIRECT: begin
                if (q.bit_op && !q.addr[7]) return {msd_pkg::MSD_TGT_RAM_LOW, 10'h020 + 10'(q.addr[6:3])};
                if (q.bit_op) return {msd_pkg::MSD_TGT_SFR, 2'h0, q.addr[7:3], 3'h0};
                return {q.addr[7] ? msd_pkg::MSD_TGT_SFR : msd_pkg::MSD_TGT_RAM_LOW, q.addr[9:0]};
            end
            msd_pkg::MSD_INDIRECT: return {q.addr[7] ? msd_pkg::MSD_TGT_RAM_HIGH : msd_pkg::MSD_TGT_RAM_LOW, q.addr[9:0]};
            msd_pkg::MSD_EXTERNAL: begin
                if (q.byte_ptr) return {msd_pkg::MSD_TGT_EXT_RAM, g, v};
                if (q.addr > 16'h02ff) return {msd_pkg::MSD_TGT_NONE, 10'h000};
                return {msd_pkg::MSD_TGT_EXT_RAM, q.addr[9:0]};
            end
            default: return {msd_pkg::MSD_TGT_NONE, 10'h000};
        endcase
    endfunction
    // Hand-written access with page, pointer and bank held at zero.
    task automatic corner(input msd_pkg::msd_kind_t k, input logic t, input logic [15:0] x);
        r        = '0;
        r.kind   = k;
        r.bit_op = t;
        r.addr   = x;
        i_core.mem(r, 8'h00, 2'h0);
        e = exp_route(r, 2'h0, 8'h00);
        chk(16'({route.target, route.ram_addr}), 16'(e));
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        {nv_trim, nv_cust0, nv_cust1} <= 24'($random(seed));
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(16'({oscillator_trim_option, customer_option_zero}), 16'({nv_trim, nv_cust0}));
        chk(16'(customer_option_one), 16'(nv_cust1));
        i_core.rd(msd_pkg::SFR_OPT_INDEX);
        chk(16'(sfr_rdata), 16'h0000);
        chk(16'(sfr_hit), 16'h0001);
        i_core.rd(msd_pkg::SFR_EXT_PAGE);
        chk(16'(sfr_rdata), 16'h0000);
    endtask
    initial begin
        repeat (2) begin
            do_reset();
            foreach (idx[n]) begin
                d = 8'($random(seed));
                i_core.wr(msd_pkg::SFR_OPT_INDEX, idx[n]);
                i_core.wr(msd_pkg::SFR_OPT_DATA, d);
                i_core.rd(msd_pkg::SFR_OPT_DATA);
                chk(16'(sfr_rdata), 16'(d));
                i_core.rd(msd_pkg::SFR_OPT_INDEX);
                chk(16'(sfr_rdata), 16'(idx[n]));
            end
            repeat (4) begin
                a = 8'h80 | 8'($random(seed));
                if (a inside {8'hf7, 8'hfe, 8'hff}) a = 8'hf8;
                i_core.wr(a, 8'hff);
                i_core.rd(a);
                chk(16'(sfr_rdata), 16'h0000);
                chk(16'(sfr_hit), 16'h0000);
            end
            chk(16'(customer_option_one), 16'(d));
            corner(msd_pkg::MSD_DIRECT, 1'b0, 16'h0090);
            corner(msd_pkg::MSD_INDIRECT, 1'b0, 16'h0090);
            corner(msd_pkg::MSD_DIRECT, 1'b1, 16'h000a);
            corner(msd_pkg::MSD_DIRECT, 1'b1, 16'h0093);
            corner(msd_pkg::MSD_INDIRECT, 1'b0, 16'h00e0);
            corner(msd_pkg::MSD_EXTERNAL, 1'b0, 16'h02ff);
            for (int g = 0; g < 4; g++) begin
                pg = 2'(g);
                i_core.wr(msd_pkg::SFR_EXT_PAGE, {6'($random(seed)), pg});
                i_core.rd(msd_pkg::SFR_EXT_PAGE);
                chk(16'(sfr_rdata), 16'({6'h00, pg}));
                repeat (12) begin
                    r = msd_pkg::msd_req_t'(20'($random(seed)));
                    r.addr &= (r.kind == msd_pkg::MSD_EXTERNAL) ? 16'h03ff : 16'h00ff;
                    r.bit_op &= (r.kind == msd_pkg::MSD_DIRECT);
                    {p, b} = 10'($random(seed));
                    i_core.mem(r, p, b);
                    e = exp_route(r, pg, p);
                    chk(16'(route.target), 16'(e[12:10]));
                    if (e[12:10] != msd_pkg::MSD_TGT_NONE) chk(16'(route.ram_addr), 16'(e[9:0]));
                    if (r.kind != msd_pkg::MSD_NONE) chk(16'(route.fault), 16'(r.kind == msd_pkg::MSD_EXTERNAL && (r.byte_ptr ? pg == 2'h3 : r.addr > 16'h02ff)));
                    if (r.bit_op) chk(16'(route.bit_pos), 16'(r.addr[2:0]));
                    chk(16'(route.bit_ok), 16'(r.bit_op));
                    chk(16'(bank_addr), 16'({b, r.addr[2:0]}));
                end
            end
        end
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
